// *** obm_pkg.sv ***
// Purpose: Shared types and constants for the operand bus master port
// Assumes: One clk_sys cycle is one half period of the processor oscillator
// Notes:   Pin-level active-low levels are named with _n
package obm_pkg;
    localparam int             OBM_ADDR_W    = 16;
    localparam int             OBM_DATA_W    = 16;
    localparam int             OBM_SYNC_W    = 5 + OBM_DATA_W;
    localparam logic           OBM_IDLE_N    = 1'b1;
    localparam logic           OBM_OE_OFF_N  = 1'b1;
    localparam logic           OBM_OSC_RST   = 1'b0;
    localparam logic           OBM_SEL_READ  = 1'b1;
    localparam logic           OBM_SEL_MEM   = 1'b1;
    localparam logic [15:0]    OBM_ZERO_WORD = 16'h0000;

    typedef enum logic [2:0] {
        OBM_IDLE,
        OBM_REQ,
        OBM_P3_LEAD,
        OBM_P3_TAIL,
        OBM_P4_WAIT,
        OBM_TERM,
        OBM_DS_UP,
        OBM_FLOAT
    } obm_state_e;

    typedef struct packed {
        logic                  is_write;
        logic                  is_io;
        logic [OBM_ADDR_W-1:0] addr;
        logic [OBM_DATA_W-1:0] wdata;
    } obm_cmd_s;

    typedef struct packed {
        logic                  grant_n;
        logic                  busy_n;
        logic                  ack_n;
        logic                  prot_n;
        logic                  berr_n;
        logic [OBM_DATA_W-1:0] data;
    } obm_pins_s;
endpackage

// *** obm_sync.sv ***
// Purpose: Two-flop synchroniser for the asynchronous bus pins
// Assumes: Each bit is an independent level
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps
module obm_sync import obm_pkg::*; #(
    parameter int             WIDTH   = OBM_SYNC_W,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1) begin : g_width_check
        $error("obm_sync width must be at least one");
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// *** obm_master.sv ***
// Purpose: Operand port bus master with request/grant arbitration
// Assumes: clk_sys ticks twice per oscillator period; osc phase is internal
// Notes:   Output enables are active low; high means the pin floats
// What this block does
// - Drive bus pins only while bus master
// - Four cycle kinds by memory/IO and read/write
// - Phase three: acknowledge grant, indicator high, address valid
// - Strobe low one clock after phase three
// - Sample transfer acknowledge each rising edge, stretch
// - End cycle half clock after acknowledge seen
// - Protect or bus error terminates cycle as error
// - Strobe high first rising edge after phase four
// - Float bus one clock after phase four
// - Request bus low at start of phase two
// - Master when grant low, busy high, falling edge
// - Hold grant acknowledge while owning the bus
// - Float grant acknowledge on giving up bus
// - Arbitration signals are all active low
// - Stretch phase two until the port is owned
// - Indicator low through phases one and two
`timescale 1ns/1ps
module obm_master import obm_pkg::*; #(
    parameter int ADDR_W = OBM_ADDR_W,
    parameter int DATA_W = OBM_DATA_W
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              op_req,
    input  wire obm_cmd_s          op_cmd,
    output logic                   op_ready,
    output logic                   op_done,
    output logic                   op_err,
    output logic [DATA_W-1:0]      op_rdata,
    output logic                   exec_phase_ind,
    output logic                   bus_request_n,
    input  wire logic              bus_grant_n,
    input  wire logic              bus_busy_n,
    output logic                   grant_ack_n,
    output logic                   grant_ack_oe_n,
    input  wire logic              transfer_ack_n,
    input  wire logic              mem_protect_err_n,
    input  wire logic              bus_error_n,
    output logic                   data_strobe_n,
    output logic                   data_strobe_oe_n,
    output logic                   rd_wr_sel,
    output logic                   mem_io_sel,
    output logic                   ctrl_oe_n,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   addr_oe_n,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_n,
    input  wire logic [DATA_W-1:0] data_i
);
    obm_state_e       state_r;
    obm_state_e       state_nxt;
    obm_cmd_s         cmd_r;
    logic             osc_hi_r;
    logic             rise_now;
    logic             fall_now;
    logic             won;
    logic             sample_hit;
    logic             sample_err;
    obm_pins_s        pins_raw;
    obm_pins_s        pins_s;

    // Synchroniser width and struct layout are fixed to the 16-bit bus
    if (ADDR_W != OBM_ADDR_W || DATA_W != OBM_DATA_W) begin : g_width_check
        $error("obm_master supports only the 16-bit operand bus");
    end

    assign pins_raw = '{grant_n: bus_grant_n, busy_n: bus_busy_n, ack_n: transfer_ack_n,
                        prot_n: mem_protect_err_n, berr_n: bus_error_n, data: data_i};

    obm_sync #(
        .WIDTH   (OBM_SYNC_W),
        .RST_VAL ({5'h1f, OBM_ZERO_WORD})
    ) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (pins_raw),
        .q       (pins_s)
    );

    // Internal oscillator phase: each clk_sys rising edge is one oscillator half period
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_hi_r <= OBM_OSC_RST;
        end else begin
            osc_hi_r <= ~osc_hi_r;
        end
    end

    assign rise_now   = ~osc_hi_r;
    assign fall_now   = osc_hi_r;
    assign won        = ~pins_s.grant_n & pins_s.busy_n;
    assign sample_err = ~pins_s.prot_n | ~pins_s.berr_n;
    assign sample_hit = ~pins_s.ack_n | sample_err;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            OBM_IDLE:    if (op_req && rise_now) state_nxt = OBM_REQ;
            OBM_REQ:     if (fall_now && won) state_nxt = OBM_P3_LEAD;
            OBM_P3_LEAD: if (rise_now) state_nxt = OBM_P3_TAIL;
            OBM_P3_TAIL: if (fall_now) state_nxt = OBM_P4_WAIT;
            OBM_P4_WAIT: if (rise_now && sample_hit) state_nxt = OBM_TERM;
            OBM_TERM:    if (fall_now) state_nxt = OBM_DS_UP;
            OBM_DS_UP:   if (rise_now) state_nxt = OBM_FLOAT;
            OBM_FLOAT:   if (fall_now) state_nxt = OBM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= OBM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Command is taken only while idle, so a request mid-cycle cannot corrupt pins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmd_r    <= '0;
            op_ready <= 1'b0;
        end else begin
            op_ready <= (state_nxt == OBM_IDLE);
            if (state_r == OBM_IDLE && state_nxt == OBM_REQ) begin
                cmd_r <= op_cmd;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus_request_n <= OBM_IDLE_N;
        end else if (state_nxt == OBM_REQ) begin
            bus_request_n <= 1'b0;
        end else begin
            bus_request_n <= OBM_IDLE_N;
        end
    end

    // Indicator low in phases one and two, high from phase three to the float
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            exec_phase_ind <= 1'b0;
        end else begin
            exec_phase_ind <= !(state_nxt == OBM_IDLE || state_nxt == OBM_REQ);
        end
    end

    // Ownership pins: grant acknowledge, address and select lines
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            grant_ack_n    <= OBM_IDLE_N;
            grant_ack_oe_n <= OBM_OE_OFF_N;
            addr_oe_n      <= OBM_OE_OFF_N;
            ctrl_oe_n      <= OBM_OE_OFF_N;
            addr_o         <= '0;
            rd_wr_sel      <= OBM_SEL_READ;
            mem_io_sel     <= OBM_SEL_MEM;
        end else if (state_r == OBM_REQ && state_nxt == OBM_P3_LEAD) begin
            grant_ack_n    <= 1'b0;
            grant_ack_oe_n <= 1'b0;
            addr_oe_n      <= 1'b0;
            ctrl_oe_n      <= 1'b0;
            addr_o         <= cmd_r.addr;
            rd_wr_sel      <= cmd_r.is_write ? ~OBM_SEL_READ : OBM_SEL_READ;
            mem_io_sel     <= cmd_r.is_io ? ~OBM_SEL_MEM : OBM_SEL_MEM;
        end else if (state_r == OBM_FLOAT && state_nxt == OBM_IDLE) begin
            grant_ack_n    <= OBM_IDLE_N;
            grant_ack_oe_n <= OBM_OE_OFF_N;
            addr_oe_n      <= OBM_OE_OFF_N;
            ctrl_oe_n      <= OBM_OE_OFF_N;
        end
    end

    // Write data go out from phase three; the data bus stays quiet on reads
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            data_o    <= '0;
            data_oe_n <= OBM_OE_OFF_N;
        end else if (state_r == OBM_REQ && state_nxt == OBM_P3_LEAD) begin
            data_o    <= cmd_r.wdata;
            data_oe_n <= ~cmd_r.is_write;
        end else if (state_r == OBM_FLOAT && state_nxt == OBM_IDLE) begin
            data_oe_n <= OBM_OE_OFF_N;
        end
    end

    // Strobe pin is enabled for the whole ownership, low from phase four to the first rising edge after it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            data_strobe_n    <= OBM_IDLE_N;
            data_strobe_oe_n <= OBM_OE_OFF_N;
        end else begin
            data_strobe_oe_n <= !(state_nxt != OBM_IDLE && state_nxt != OBM_REQ);
            if (state_r == OBM_P3_TAIL && state_nxt == OBM_P4_WAIT) begin
                data_strobe_n <= 1'b0;
            end else if (state_r == OBM_DS_UP && state_nxt == OBM_FLOAT) begin
                data_strobe_n <= OBM_IDLE_N;
            end
        end
    end

    // Result is latched at the sampling edge but reported when the cycle ends
    logic              err_hold_r;
    logic [DATA_W-1:0] rd_hold_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            err_hold_r <= 1'b0;
            rd_hold_r  <= '0;
            op_done    <= 1'b0;
            op_err     <= 1'b0;
            op_rdata   <= '0;
        end else begin
            op_done <= 1'b0;
            op_err  <= 1'b0;
            if (state_r == OBM_P4_WAIT && state_nxt == OBM_TERM) begin
                err_hold_r <= sample_err;
                rd_hold_r  <= pins_s.data;
            end
            if (state_r == OBM_TERM && state_nxt == OBM_DS_UP) begin
                op_done <= 1'b1;
                op_err  <= err_hold_r;
                if (!cmd_r.is_write && !err_hold_r) begin
                    op_rdata <= rd_hold_r;
                end
            end
        end
    end
endmodule

// *** obm_monitor.sv ***
// Purpose: Pin-level checks on the operand bus master
// Assumes: Pin inputs reach the control logic two samples late and show at the outputs three samples late
// Notes:   Watches design outputs plus op_req and the arbitration and response pin inputs
`timescale 1ns/1ps
module obm_monitor (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic op_req,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic op_err,
    input wire logic exec_phase_ind,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic bus_busy_n,
    input wire logic grant_ack_n,
    input wire logic grant_ack_oe_n,
    input wire logic transfer_ack_n,
    input wire logic mem_protect_err_n,
    input wire logic bus_error_n,
    input wire logic data_strobe_n,
    input wire logic rd_wr_sel,
    input wire logic ctrl_oe_n,
    input wire logic addr_oe_n,
    input wire logic data_oe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_own; !ctrl_oe_n |-> !grant_ack_n && !grant_ack_oe_n; endproperty
    a_own: assert property (p_own) else $error("pins driven without ownership");
    property p_p3; $fell(grant_ack_n) |-> !ctrl_oe_n && !addr_oe_n && exec_phase_ind && bus_request_n; endproperty
    a_p3: assert property (p_p3) else $error("phase three outputs not together");
    property p_ds; $fell(grant_ack_n) |-> data_strobe_n ##1 data_strobe_n ##1 !data_strobe_n; endproperty
    a_ds: assert property (p_ds) else $error("strobe not one clock after phase three");
    property p_wait; (transfer_ack_n && mem_protect_err_n && bus_error_n) [*4] |=> !op_done; endproperty
    a_wait: assert property (p_wait) else $error("cycle ended without acknowledge");
    property p_end; op_done |-> !data_strobe_n ##1 data_strobe_n; endproperty
    a_end: assert property (p_end) else $error("strobe release timing wrong");
    property p_err; op_err |-> op_done; endproperty
    a_err: assert property (p_err) else $error("error flag outside cycle end");
    property p_float; op_done |-> ##2 (ctrl_oe_n && addr_oe_n && grant_ack_oe_n && op_ready); endproperty
    a_float: assert property (p_float) else $error("bus not floated after cycle");
    property p_req; $fell(bus_request_n) |-> $past(op_req && op_ready); endproperty
    a_req: assert property (p_req) else $error("request without command");
    property p_win; $fell(grant_ack_n) |-> $past(!bus_grant_n && bus_busy_n, 3); endproperty
    a_win: assert property (p_win) else $error("bus taken without grant");
    property p_ind; !exec_phase_ind |-> ctrl_oe_n && addr_oe_n; endproperty
    a_ind: assert property (p_ind) else $error("indicator low while driving");
    property p_wr; !data_oe_n |-> !rd_wr_sel && !ctrl_oe_n; endproperty
    a_wr: assert property (p_wr) else $error("data driven on a read");
endmodule
bind obm_master obm_monitor u_mon (.*);

// *** obm_far_model.sv ***
// Purpose: Arbiter, other master and slave beside the port
// Assumes: Arbiter grants whenever asked
// Notes:   Released data lines show a changing pattern
`timescale 1ns/1ps
module obm_far_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        bus_request_n,
    input  wire logic        data_strobe_n,
    input  wire logic        rd_wr_sel,
    input  wire logic        other_busy,
    input  wire logic [3:0]  ack_wait,
    input  wire logic [1:0]  err_kind,
    input  wire logic [15:0] rd_word,
    output logic             bus_grant_n,
    output logic             bus_busy_n,
    output logic             transfer_ack_n,
    output logic             mem_protect_err_n,
    output logic             bus_error_n,
    output logic [15:0]      data_i
);
    logic [3:0]  wait_r;
    logic [15:0] last_r;
    logic        resp;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) wait_r <= 4'h0;
        else if (data_strobe_n) wait_r <= 4'h0;
        else if (wait_r != 4'hf) wait_r <= wait_r + 4'h1;
    end
    // Reset start keeps the released pattern known; an unknown seed would never toggle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) last_r <= 16'h0000;
        else last_r <= data_i;
    end
    assign resp = !data_strobe_n && (wait_r >= ack_wait);
    assign transfer_ack_n = !(resp && err_kind == 2'h0);
    assign mem_protect_err_n = !(resp && err_kind == 2'h1);
    assign bus_error_n = !(resp && err_kind == 2'h2);
    assign bus_grant_n = bus_request_n;
    assign bus_busy_n = !other_busy;
    assign data_i = (!data_strobe_n && rd_wr_sel) ? rd_word : ~last_r;
endmodule

// *** test_operand_bus_master_port.sv ***
// Purpose: Self-checking bench for the operand bus master
// Assumes: Inputs change 5 ns after the rising clock edge
// Notes:   Expectations come from task arguments, rd_word and the previous op_rdata
`timescale 1ns/1ps
module test_operand_bus_master_port;
    import obm_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, op_req = 1'b0, other_busy = 1'b0;
    obm_cmd_s op_cmd = '0;
    logic [3:0] ack_wait = 4'h0;
    logic [1:0] err_kind = 2'h0;
    logic [15:0] rd_word = 16'h5a3c, op_rdata, addr_o, data_o, data_i;
    logic op_ready, op_done, op_err, exec_phase_ind, bus_request_n, bus_grant_n, bus_busy_n, grant_ack_n;
    logic grant_ack_oe_n, transfer_ack_n, mem_protect_err_n, bus_error_n, data_strobe_n, data_strobe_oe_n;
    logic rd_wr_sel, mem_io_sel, ctrl_oe_n, addr_oe_n, data_oe_n;
    int bad_count = 0, n_tests = 0;
    always #25 clk_sys = ~clk_sys;
    obm_master dut (.*);
    obm_far_model far (.*);
    task automatic tick();
        @(posedge clk_sys);
        #5;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic run_op(input logic wr, io, input logic [15:0] a, d, input logic [1:0] ek,
                          input logic [3:0] aw, input int bh);
        logic [15:0] prev;
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        prev = op_rdata;
        err_kind = ek;
        ack_wait = aw;
        other_busy = (bh != 0);
        op_cmd = '{is_write: wr, is_io: io, addr: a, wdata: d};
        op_req = 1'b1;
        while (bus_request_n !== 1'b0 && n < 40) begin
            tick();
            n++;
        end
        op_req = 1'b0;
        repeat (bh) begin
            tick();
            check("ctrl_oe_n", ctrl_oe_n, 16'h1);
            check("bus_request_n", bus_request_n, 16'h0);
        end
        other_busy = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 60) begin
            if (ctrl_oe_n === 1'b0) begin
                check("mem_io_sel", mem_io_sel, io ? 16'h0 : 16'h1);
                check("rd_wr_sel", rd_wr_sel, wr ? 16'h0 : 16'h1);
                check("addr_o", addr_o, a);
                check("exec_phase_ind", exec_phase_ind, 16'h1);
                check("grant_ack_n", grant_ack_n, 16'h0);
                check("data_strobe_oe_n", data_strobe_oe_n, 16'h0);
                check("data_oe_n", data_oe_n, wr ? 16'h0 : 16'h1);
                if (wr) check("data_o", data_o, d);
            end
            tick();
            n++;
        end
        check("op_done", op_done, 16'h1);
        check("op_err", op_err, (ek != 2'h0) ? 16'h1 : 16'h0);
        check("op_rdata", op_rdata, (wr || ek != 2'h0) ? prev : rd_word);
        tick();
        tick();
        check("addr_oe_n", addr_oe_n, 16'h1);
        check("grant_ack_oe_n", grant_ack_oe_n, 16'h1);
        check("exec_phase_ind", exec_phase_ind, 16'h0);
    endtask
    task automatic test_idle();
        check("bus_request_n", bus_request_n, 16'h1);
        check("ctrl_oe_n", ctrl_oe_n, 16'h1);
        check("data_strobe_oe_n", data_strobe_oe_n, 16'h1);
        check("exec_phase_ind", exec_phase_ind, 16'h0);
        $display("test idle done");
    endtask
    task automatic test_kinds();
        for (int k = 0; k < 8; k++) begin
            rd_word = 16'h1200 + 16'(k);
            run_op(k[0], k[1], 16'hf0f0 ^ 16'(k), 16'ha5a5 + 16'(k), 2'h0, k[2] ? 4'h6 : 4'h0, 0);
        end
        $display("test kinds done");
    endtask
    task automatic test_errors();
        run_op(1'b0, 1'b0, 16'h0102, 16'h0, 2'h1, 4'h2, 0);
        run_op(1'b0, 1'b1, 16'hfffe, 16'h0, 2'h2, 4'h0, 0);
        $display("test errors done");
    endtask
    task automatic test_busy();
        run_op(1'b1, 1'b0, 16'h8001, 16'h7e81, 2'h0, 4'h1, 12);
        $display("test busy done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #5;
        nrst = 1'b1;
        tick();
        tick();
        test_idle();
        test_kinds();
        test_errors();
        test_busy();
        finish_test();
    end
endmodule
